// ---- fff_fifo.sv ----
/*
 * Top of the 16 x 5 first-in first-out buffer: strobe decoding, pointers,
 * occupancy, status flags and the output data register with its enable.
 * Assumes every pin is synchronous to clock and that strobe edges come no
 * faster than the sampled rate allows; the read bus three-state is resolved
 * outside from read_word_oe_n.
 */
`timescale 1ns/1ps
`default_nettype none
module fff_fifo (
   input  wire  logic               clock,               // system clock, 100 MHz
   input  wire  logic               rst,                 // synchronous reset, high
   input  wire  logic               load_strobe_a,       // load strobe a, rising edge writes
   input  wire  logic               load_strobe_b,       // load strobe b, rising edge writes
   input  wire  fff_pkg::fff_word_t write_word_in,       // word to write
   input  wire  logic               unload_strobe_in,    // unload strobe, idles high
   input  wire  logic               flush_n,             // flush, falling edge clears
   input  wire  logic               output_enable_n,     // read bus enable, low drives
   output fff_pkg::fff_word_t       read_word_out,       // oldest stored word
   output logic                     read_word_oe_n,      // low while read bus driven
   output logic                     write_space_flag,    // room for a word
   output logic                     read_valid_flag,     // output word valid
   output logic                     vacancy_pulse_out_n  // one-cycle low on last slot freed
);
   fff_pkg::fff_strobe_t pins;
   fff_pkg::fff_strobe_t rise;
   fff_pkg::fff_strobe_t fall;

   logic [fff_pkg::FFF_PTR_W-1:0] wr_ptr_q;
   logic [fff_pkg::FFF_PTR_W-1:0] wr_ptr_d;
   logic [fff_pkg::FFF_PTR_W-1:0] rd_ptr_q;
   logic [fff_pkg::FFF_PTR_W-1:0] rd_ptr_d;
   logic [fff_pkg::FFF_CNT_W-1:0] count_q;
   logic [fff_pkg::FFF_CNT_W-1:0] count_d;
   fff_pkg::fff_state_t           state_q;
   fff_pkg::fff_state_t           state_d;
   fff_pkg::fff_status_t          status_q;
   fff_pkg::fff_status_t          status_d;
   fff_pkg::fff_word_t            word_q;
   fff_pkg::fff_word_t            word_d;
   fff_pkg::fff_word_t            head_word;

   logic write_req;
   logic unload_req;
   logic flush_start;
   logic clearing;
   logic do_write;
   logic do_read;
   logic full_now;
   logic empty_now;
   logic head_from_input;

   assign pins.load_a  = load_strobe_a;
   assign pins.load_b  = load_strobe_b;
   assign pins.unload  = unload_strobe_in;
   assign pins.flush_n = flush_n;

   // each strobe is sampled on its own, so writer and reader need no relation
   fff_edge u_edge (
      .clock (clock),
      .rst   (rst),
      .level (pins),
      .rise  (rise),
      .fall  (fall)
   );

   fff_store u_store (
      .clock   (clock),
      .wr_en   (do_write),
      .wr_idx  (wr_ptr_q),
      .wr_word (write_word_in),
      .rd_idx  (rd_ptr_d),
      .rd_word (head_word)
   );

   // request decoding
   always_comb begin
      // the held partner strobe cannot rise, so it inhibits by construction
      write_req   = rise.load_a | rise.load_b;
      unload_req  = rise.unload;
      flush_start = fall.flush_n;
      // control stays cleared while the flush pin is held low
      clearing    = flush_start | (state_q == fff_pkg::FFF_ST_CLEAR);
      full_now    = (count_q == fff_pkg::FFF_CNT_FULL);
      empty_now   = (count_q == fff_pkg::FFF_CNT_EMPTY);
      do_write    = write_req & ~full_now & ~clearing;
      do_read     = unload_req & ~empty_now & ~clearing;
   end

   // pointers and occupancy
   always_comb begin
      wr_ptr_d = wr_ptr_q;
      rd_ptr_d = rd_ptr_q;
      count_d  = count_q;
      if (clearing) begin
         wr_ptr_d = fff_pkg::FFF_PTR_RST;
         rd_ptr_d = fff_pkg::FFF_PTR_RST;
         count_d  = fff_pkg::FFF_CNT_EMPTY;
      end else begin
         if (do_write) begin
            // pointer wraps at 16 by its own width
            wr_ptr_d = wr_ptr_q + fff_pkg::FFF_PTR_ONE;
         end
         if (do_read) begin
            rd_ptr_d = rd_ptr_q + fff_pkg::FFF_PTR_ONE;
         end
         case ({do_write, do_read})
            2'h2: begin
               count_d = count_q + fff_pkg::FFF_CNT_ONE;
            end
            2'h1: begin
               count_d = count_q - fff_pkg::FFF_CNT_ONE;
            end
            default: begin
               count_d = count_q;
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         wr_ptr_q <= fff_pkg::FFF_PTR_RST;
         rd_ptr_q <= fff_pkg::FFF_PTR_RST;
         count_q  <= fff_pkg::FFF_CNT_EMPTY;
      end else begin
         wr_ptr_q <= wr_ptr_d;
         rd_ptr_q <= rd_ptr_d;
         count_q  <= count_d;
      end
   end

   // occupancy state
   always_comb begin
      case (state_q)
         fff_pkg::FFF_ST_CLEAR: begin
            // release of the flush pin returns to empty
            if (flush_n) begin
               state_d = fff_pkg::FFF_ST_EMPTY;
            end else begin
               state_d = fff_pkg::FFF_ST_CLEAR;
            end
         end
         fff_pkg::FFF_ST_EMPTY,
         fff_pkg::FFF_ST_PARTIAL,
         fff_pkg::FFF_ST_FULL: begin
            if (flush_start) begin
               state_d = fff_pkg::FFF_ST_CLEAR;
            end else if (count_d == fff_pkg::FFF_CNT_EMPTY) begin
               state_d = fff_pkg::FFF_ST_EMPTY;
            end else if (count_d == fff_pkg::FFF_CNT_FULL) begin
               state_d = fff_pkg::FFF_ST_FULL;
            end else begin
               state_d = fff_pkg::FFF_ST_PARTIAL;
            end
         end
         default: begin
            state_d = fff_pkg::FFF_ST_EMPTY;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_q <= fff_pkg::FFF_ST_EMPTY;
      end else begin
         state_q <= state_d;
      end
   end

   // status flags
   always_comb begin
      status_d.write_space = (count_d != fff_pkg::FFF_CNT_FULL);
      status_d.held_valid  = (count_d != fff_pkg::FFF_CNT_EMPTY) & ~clearing;
      // the pulse marks the cycle the last slot turns vacant, by unload or flush
      status_d.vacancy_n   = ~(full_now & (count_d != fff_pkg::FFF_CNT_FULL));
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         status_q.write_space <= 1'b1;
         status_q.held_valid  <= 1'b0;
         status_q.vacancy_n   <= 1'b1;
      end else begin
         status_q <= status_d;
      end
   end

   // output data register
   always_comb begin
      // an empty buffer that is written in the same cycle shows the new word
      head_from_input = do_write & (count_q == fff_pkg::FFF_CNT_EMPTY);
      word_d = word_q;
      if (clearing) begin
         word_d = word_q;
      end else if (head_from_input) begin
         word_d = write_word_in;
      end else if (count_d != fff_pkg::FFF_CNT_EMPTY) begin
         // write and read of a single word together leave the new word at the head
         if (do_write && do_read && (count_q == fff_pkg::FFF_CNT_ONE)) begin
            word_d = write_word_in;
         end else begin
            word_d = head_word;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         word_q <= fff_pkg::FFF_WORD_RST;
      end else begin
         word_q <= word_d;
      end
   end

   assign read_word_out       = word_q;
   // enable passes straight through so floating never stalls writes or reads
   assign read_word_oe_n      = output_enable_n;
   assign write_space_flag    = status_q.write_space;
   // gated by the live unload level: a held-low strobe hides the word at once
   assign read_valid_flag     = status_q.held_valid & unload_strobe_in;
   assign vacancy_pulse_out_n = status_q.vacancy_n;
endmodule
`default_nettype wire

// ---- fff_pkg.sv ----
/*
 * Constants, types and field layout for the 16 x 5 first-in first-out buffer.
 * Assumes one 100 MHz clock and strobe pins that arrive synchronous to it.
 */
// Function
// - The buffer holds 16 five-bit words and gives them to the reader in the order written.
// - A word is taken from the write inputs on the rising edge of either load strobe.
// - The reader keeps the unload strobe high when idle, and its rising edge advances to the next word.
// - The write-space flag is high while the last position can take a word and low when full.
// - A one-cycle low vacancy pulse is given whenever the last position becomes vacant.
// - Read-valid is high only while the output position holds a word and the unload strobe is high.
// - Read-valid is forced low for as long as the unload strobe is low.
// - The read outputs always show the first position, the oldest stored word.
// - The read outputs carry the written bits without inversion.
// - While the shared output enable is low all five read outputs are driven.
// - While the output enable is high the read outputs float and everything else keeps working.
// - The falling edge of the low flush pulse resets control, invalidates all words and drops read-valid.
// - A flush leaves the read output levels as they were; only read-valid says they are stale.
// - Write and unload strobes are independent and work at any rate from static up to 10 MHz.
package fff_pkg;

   localparam int unsigned FFF_DEPTH    = 16;
   localparam int unsigned FFF_WIDTH    = 5;
   localparam int unsigned FFF_PTR_W    = 4;
   localparam int unsigned FFF_CNT_W    = 5;
   localparam int unsigned FFF_N_STROBE = 4;

   // bit positions of the strobe group inside the edge detector vector
   localparam int unsigned FFF_IDX_LOAD_A = 0;
   localparam int unsigned FFF_IDX_LOAD_B = 1;
   localparam int unsigned FFF_IDX_UNLOAD = 2;
   localparam int unsigned FFF_IDX_FLUSH  = 3;

   // every strobe resets as if high: the writer holds one load strobe high, so a low
   // reset value there would raise a false write at the first edge after reset
   localparam logic [FFF_N_STROBE-1:0] FFF_STROBE_IDLE = 4'hF;

   localparam logic [FFF_CNT_W-1:0] FFF_CNT_FULL  = 5'h10;
   localparam logic [FFF_CNT_W-1:0] FFF_CNT_EMPTY = 5'h00;
   localparam logic [FFF_CNT_W-1:0] FFF_CNT_ONE   = 5'h01;
   localparam logic [FFF_PTR_W-1:0] FFF_PTR_RST   = 4'h0;
   localparam logic [FFF_PTR_W-1:0] FFF_PTR_ONE   = 4'h1;
   localparam logic [FFF_WIDTH-1:0] FFF_WORD_RST  = 5'h00;

   // strobe rate versus sampling clock: edges spaced at least this many cycles
   localparam int unsigned FFF_CLK_MHZ         = 100;
   localparam int unsigned FFF_STROBE_MAX_MHZ  = 10;
   localparam int unsigned FFF_STROBE_MIN_CYC  = FFF_CLK_MHZ / FFF_STROBE_MAX_MHZ;

   typedef logic [FFF_WIDTH-1:0] fff_word_t;

   typedef struct packed {
      logic flush_n;
      logic unload;
      logic load_b;
      logic load_a;
   } fff_strobe_t;

   typedef struct packed {
      logic write_space;
      logic held_valid;
      logic vacancy_n;
   } fff_status_t;

   typedef enum logic [1:0] {
      FFF_ST_EMPTY,
      FFF_ST_PARTIAL,
      FFF_ST_FULL,
      FFF_ST_CLEAR
   } fff_state_t;

endpackage

// ---- fff_edge.sv ----
/*
 * Rising and falling edge detection for the strobe pins.
 * Assumes the pins are already synchronous to clock.
 */
`timescale 1ns/1ps
`default_nettype none
module fff_edge (
   input  wire  logic                            clock, // system clock
   input  wire  logic                            rst,   // synchronous reset, high
   input  wire  logic [fff_pkg::FFF_N_STROBE-1:0] level, // present pin levels
   output logic       [fff_pkg::FFF_N_STROBE-1:0] rise,  // low-to-high this cycle
   output logic       [fff_pkg::FFF_N_STROBE-1:0] fall   // high-to-low this cycle
);
   logic [fff_pkg::FFF_N_STROBE-1:0] prev_q;
   logic [fff_pkg::FFF_N_STROBE-1:0] prev_d;

   always_comb begin
      prev_d = level;
   end

   // reset to idle levels so a pin resting at idle raises no edge
   always_ff @(posedge clock) begin
      if (rst) begin
         prev_q <= fff_pkg::FFF_STROBE_IDLE;
      end else begin
         prev_q <= prev_d;
      end
   end

   genvar g;
   generate
      for (g = 0; g < fff_pkg::FFF_N_STROBE; g++) begin : g_bit
         assign rise[g] = level[g] & ~prev_q[g];
         assign fall[g] = ~level[g] & prev_q[g];
      end
   endgenerate
endmodule
`default_nettype wire

// ---- fff_store.sv ----
/*
 * Sixteen five-bit storage words in flip-flops, one write port, one read index.
 * Assumes the caller never writes while full.
 */
`timescale 1ns/1ps
`default_nettype none
module fff_store (
   input  wire  logic                          clock,    // system clock
   input  wire  logic                          wr_en,    // store word this cycle
   input  wire  logic [fff_pkg::FFF_PTR_W-1:0] wr_idx,   // entry to write
   input  wire  fff_pkg::fff_word_t            wr_word,  // word to store
   input  wire  logic [fff_pkg::FFF_PTR_W-1:0] rd_idx,   // entry to show
   output fff_pkg::fff_word_t                  rd_word   // word at rd_idx
);
   fff_pkg::fff_word_t mem_q [fff_pkg::FFF_DEPTH];

   // contents need no reset: validity lives in the controller's count
   genvar g;
   generate
      for (g = 0; g < fff_pkg::FFF_DEPTH; g++) begin : g_entry
         fff_pkg::fff_word_t entry_d;
         always_comb begin
            entry_d = mem_q[g];
            if (wr_en && (wr_idx == (fff_pkg::FFF_PTR_W)'(g))) begin
               entry_d = wr_word;
            end
         end
         always_ff @(posedge clock) begin
            mem_q[g] <= entry_d;
         end
      end
   endgenerate

   assign rd_word = mem_q[rd_idx];
endmodule
`default_nettype wire

// ---- fff_props.sv ----
/*
 * Checker for the fifo top: flag, pulse, flush and enable relations.
 * Assumes the single clock and the bind at the foot of this file.
 */
`timescale 1ns/1ps
`default_nettype none
module fff_props (
   input wire logic               clock,               // system clock
   input wire logic               rst,                 // reset, high
   input wire logic               load_strobe_a,       // load a
   input wire logic               load_strobe_b,       // load b
   input wire fff_pkg::fff_word_t write_word_in,       // word in
   input wire logic               unload_strobe_in,    // unload
   input wire logic               flush_n,             // flush, low
   input wire logic               output_enable_n,     // bus enable
   input wire fff_pkg::fff_word_t read_word_out,       // head word
   input wire logic               read_word_oe_n,      // bus driven, low
   input wire logic               write_space_flag,    // room
   input wire logic               read_valid_flag,     // valid
   input wire logic               vacancy_pulse_out_n  // vacancy, low
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   property p_valid_gated; !unload_strobe_in |-> !read_valid_flag; endproperty
   a_valid_gated: assert property (p_valid_gated) else $error("valid with unload low");
   property p_oe_pass; read_word_oe_n == output_enable_n; endproperty
   a_oe_pass: assert property (p_oe_pass) else $error("bus enable mismatch");
   property p_flush_clear; $fell(flush_n) |=> !read_valid_flag && write_space_flag; endproperty
   a_flush_clear: assert property (p_flush_clear) else $error("flush left flags set");
   property p_flush_keep; $fell(flush_n) |=> $stable(read_word_out); endproperty
   a_flush_keep: assert property (p_flush_keep) else $error("flush moved data");
   property p_vac_short; !vacancy_pulse_out_n |=> vacancy_pulse_out_n; endproperty
   a_vac_short: assert property (p_vac_short) else $error("vacancy pulse too long");
   property p_vac_cause; $fell(vacancy_pulse_out_n) |-> !$past(write_space_flag); endproperty
   a_vac_cause: assert property (p_vac_cause) else $error("vacancy without full");
   property p_full_hold; !write_space_flag && flush_n && !$rose(unload_strobe_in) |=> !write_space_flag; endproperty
   a_full_hold: assert property (p_full_hold) else $error("full state lost");
   property p_fill_cause;
      $fell(write_space_flag) |-> ($past(load_strobe_a) && !$past(load_strobe_a, 2))
                                || ($past(load_strobe_b) && !$past(load_strobe_b, 2));
   endproperty
   a_fill_cause: assert property (p_fill_cause) else $error("full without write");
   property p_first_word;
      !read_valid_flag && unload_strobe_in && $stable(unload_strobe_in) && flush_n && $stable(flush_n)
      && ($rose(load_strobe_a) || $rose(load_strobe_b))
      |=> read_valid_flag && read_word_out == $past(write_word_in);
   endproperty
   a_first_word: assert property (p_first_word) else $error("first word not shown");
endmodule
bind fff_fifo fff_props i_fff_props (.clock(clock), .rst(rst), .load_strobe_a(load_strobe_a),
   .load_strobe_b(load_strobe_b), .write_word_in(write_word_in), .unload_strobe_in(unload_strobe_in),
   .flush_n(flush_n), .output_enable_n(output_enable_n), .read_word_out(read_word_out),
   .read_word_oe_n(read_word_oe_n), .write_space_flag(write_space_flag), .read_valid_flag(read_valid_flag),
   .vacancy_pulse_out_n(vacancy_pulse_out_n));
`default_nettype wire

// ---- fff_partner.sv ----
/*
 * Producer and consumer model for the fifo: strobes, word lines, read bus.
 * Assumes its tasks are entered at a falling edge of clock.
 */
`timescale 1ns/1ps
`default_nettype none
module fff_partner (
   input  wire logic               clock,            // system clock
   output logic                    load_strobe_a,    // load a
   output logic                    load_strobe_b,    // load b
   output fff_pkg::fff_word_t      write_word_in,    // word to fifo
   output logic                    unload_strobe_in, // unload
   input  wire fff_pkg::fff_word_t read_word_out,    // fifo data
   input  wire logic               read_word_oe_n,   // bus enable
   output fff_pkg::fff_word_t      bus               // resolved read bus
);
   localparam int HALF = fff_pkg::FFF_STROBE_MIN_CYC / 2;
   fff_pkg::fff_word_t last_q;
   logic               use_b;
   // bus has no pull: a floating bus shows the inverse, never a stale match
   assign bus = read_word_oe_n ? ~last_q : read_word_out;
   always @(posedge clock) if (!read_word_oe_n) last_q <= read_word_out;
   initial begin
      last_q = 5'h00;
      use_b = 1'b0;
      load_strobe_a = 1'b0;
      load_strobe_b = 1'b1;
      unload_strobe_in = 1'b1;
      write_word_in = 5'h00;
   end
   task automatic hold(input logic b);
      use_b = b;
      load_strobe_a = b;
      load_strobe_b = !b;
   endtask
   task automatic put(input fff_pkg::fff_word_t w);
      write_word_in = w;
      if (use_b) load_strobe_b = 1'b1; else load_strobe_a = 1'b1;
      repeat (HALF) @(negedge clock);
      if (use_b) load_strobe_b = 1'b0; else load_strobe_a = 1'b0;
      // hold time is over, so the word lines stop showing the word
      write_word_in = ~w;
      repeat (HALF) @(negedge clock);
   endtask
   task automatic take();
      // strobe idles high, so two toggles give one low pulse
      unload_strobe_in = ~unload_strobe_in;
      repeat (HALF) @(negedge clock);
      unload_strobe_in = ~unload_strobe_in;
      repeat (HALF) @(negedge clock);
   endtask
endmodule
`default_nettype wire

// ---- fff_fifo_bench.sv ----
/*
 * Self-checking bench for the 16 x 5 fifo driven through its partner model.
 * Assumes the partner changes strobes at falling edges only.
 */
`timescale 1ns/1ps
`default_nettype none
module fff_fifo_bench;
   logic               clock, rst, flush_n, output_enable_n, load_strobe_a, load_strobe_b;
   logic               unload_strobe_in, read_word_oe_n, write_space_flag, read_valid_flag;
   logic               vacancy_pulse_out_n;
   fff_pkg::fff_word_t write_word_in, read_word_out, bus;
   int                 errors, n_compared;
   int                 n_vac = 0;
   fff_fifo i_fff_fifo (.clock(clock), .rst(rst), .load_strobe_a(load_strobe_a), .load_strobe_b(load_strobe_b),
      .write_word_in(write_word_in), .unload_strobe_in(unload_strobe_in), .flush_n(flush_n),
      .output_enable_n(output_enable_n), .read_word_out(read_word_out), .read_word_oe_n(read_word_oe_n),
      .write_space_flag(write_space_flag), .read_valid_flag(read_valid_flag),
      .vacancy_pulse_out_n(vacancy_pulse_out_n));
   fff_partner i_fff_partner (.clock(clock), .load_strobe_a(load_strobe_a), .load_strobe_b(load_strobe_b),
      .write_word_in(write_word_in), .unload_strobe_in(unload_strobe_in), .read_word_out(read_word_out),
      .read_word_oe_n(read_word_oe_n), .bus(bus));
   always #5 clock = ~clock;
   always @(posedge clock) if (vacancy_pulse_out_n === 1'b0) n_vac++;
   task automatic report_and_stop();
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_word(input fff_pkg::fff_word_t got, input fff_pkg::fff_word_t exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic fff_pkg::fff_word_t pat(input int i);
      return 5'(i * 3 + 7);
   endfunction
   task automatic drive_flush(input logic v);
      flush_n = v;
   endtask
   task automatic drive_oe(input logic v);
      output_enable_n = v;
   endtask
   task automatic do_reset(input logic b);
      rst = 1'b1;
      i_fff_partner.hold(b);
      repeat (5) @(negedge clock);
      rst = 1'b0;
      @(negedge clock);
   endtask
   task automatic t_fill_drain();
      int i;
      int vac0;
      for (i = 0; i < 16; i++) i_fff_partner.put(pat(i));
      chk_bit(write_space_flag, 1'b0);
      i_fff_partner.put(5'h1F);
      vac0 = n_vac;
      for (i = 0; i < 16; i++) begin
         chk_bit(read_valid_flag, 1'b1);
         chk_word(read_word_out, pat(i));
         i_fff_partner.take();
         chk_bit(write_space_flag, 1'b1);
      end
      chk_bit(n_vac - vac0 == 1, 1'b1);
      chk_bit(read_valid_flag, 1'b0);
      i_fff_partner.take();
      chk_bit(read_valid_flag, 1'b0);
   endtask
   task automatic t_flush_enable();
      drive_oe(1'b1);
      i_fff_partner.put(5'h0A);
      i_fff_partner.put(5'h15);
      chk_bit(read_word_oe_n, 1'b1);
      chk_bit(read_valid_flag, 1'b1);
      drive_oe(1'b0);
      @(negedge clock);
      chk_bit(read_word_oe_n, 1'b0);
      chk_word(bus, 5'h0A);
      drive_flush(1'b0);
      repeat (4) @(negedge clock);
      chk_bit(read_valid_flag, 1'b0);
      chk_bit(write_space_flag, 1'b1);
      chk_word(read_word_out, 5'h0A);
      i_fff_partner.put(5'h03);
      drive_flush(1'b1);
      @(negedge clock);
      chk_bit(read_valid_flag, 1'b0);
      i_fff_partner.put(5'h0C);
      chk_word(read_word_out, 5'h0C);
      i_fff_partner.take();
      chk_bit(read_valid_flag, 1'b0);
   endtask
   task automatic t_strobe_b();
      do_reset(1'b1);
      chk_bit(read_valid_flag, 1'b0);
      chk_bit(vacancy_pulse_out_n, 1'b1);
      i_fff_partner.put(5'h11);
      i_fff_partner.put(5'h0E);
      chk_word(read_word_out, 5'h11);
      i_fff_partner.take();
      chk_word(read_word_out, 5'h0E);
      // pop of the single word and a new write land on the same clock edge
      fork
         i_fff_partner.take();
         begin
            repeat (fff_pkg::FFF_STROBE_MIN_CYC / 2) @(negedge clock);
            i_fff_partner.put(5'h07);
         end
      join
      chk_word(read_word_out, 5'h07);
      chk_bit(read_valid_flag, 1'b1);
   endtask
   // the whole run needs about 450 cycles; this leaves ample margin
   initial begin
      #50000;
      errors++;
      report_and_stop();
   end
   initial begin
      clock = 1'b0;
      drive_flush(1'b1);
      drive_oe(1'b0);
      errors = 0;
      n_compared = 0;
      do_reset(1'b0);
      chk_bit(write_space_flag, 1'b1);
      chk_bit(read_valid_flag, 1'b0);
      t_fill_drain();
      t_flush_enable();
      t_strobe_b();
      report_and_stop();
   end
endmodule
`default_nettype wire
